//--- rtl/sdvt_consts.vh
// constants for the sd video encoder timing and sync generator
// assumes an apb master on the same clock and external sync pins
// Function
// R1 - encoder_run at 0 holds timing logic in reset; 1 starts it
// R2 - master_slave_sel 1 locks to external syncs; 0 free-runs as master
// R3 - field_detect_sel picks slave field source: latch, raw, vsync, phase
// R4 - field_in_invert 1 inverts the external field input
// R5 - sync input polarity bits: 0 active high, 1 active low
// R6 - lines_per_frame is thirteen bits, reset 20Dh
// R7 - clocks_per_line is thirteen bits, reset 6B4h
// R8 - output polarity bits: 0 active high, 1 active low; field inverted
// R9 - hsync out asserted from start pixel to stop pixel each line
// R10 - vsync out between start and stop lines, edges at set pixels
// R11 - field out toggles at set pixel on each field's start line
// R12 - start-field bits give field value at each start line; f1 resets 1
// R13 - in progressive mode field0 start bit forces field toggle
// R14 - active video out within pixel window and per-field line window
// R15 - detect pulse out inside pixel and line window
// R16 - interrupt pulse at set line and pixel of the frame
// R17 - even caption pending set on write, cleared after line 284 or 335
// R18 - odd caption pending set on write, cleared after line 21 or 22
// R19 - scan_format 0 is 525 interlaced, 1 is 625; others reserved
// R20 - unequal_field_lines alternates field lengths (n-1)/2 and (n+1)/2; here only field_len_cnt alternates, when interlaced, and drives no output
// R21 - pixel counter wraps at clocks_per_line, line counter at frame
`ifndef SDVT_CONSTS_VH
`define SDVT_CONSTS_VH
// ==================================================
// register byte offsets
`define SDVT_OFS_MODE 12'h004
`define SDVT_OFS_SLAVE 12'h008
`define SDVT_OFS_SIZE 12'h00C
`define SDVT_OFS_POL 12'h010
`define SDVT_OFS_HS 12'h014
`define SDVT_OFS_VSP 12'h018
`define SDVT_OFS_VSL 12'h01C
`define SDVT_OFS_FTP 12'h020
`define SDVT_OFS_FST 12'h024
`define SDVT_OFS_AVP 12'h028
`define SDVT_OFS_AVL0 12'h02C
`define SDVT_OFS_AVL1 12'h030
`define SDVT_OFS_DTP 12'h054
`define SDVT_OFS_DTL 12'h058
`define SDVT_OFS_IRQ 12'h05C
`define SDVT_OFS_STAT 12'h080
`define SDVT_OFS_CTL 12'h084
`define SDVT_OFS_CCE 12'h128
`define SDVT_OFS_CCO 12'h12C
// ==================================================
// reset values and write masks
`define SDVT_RST_SIZE 32'h020D06B4
`define SDVT_RST_FST 32'h20000000
`define SDVT_RST_MODE 32'h00000004
`define SDVT_MSK_PAIR 32'h1FFF1FFF
`define SDVT_MSK_FST 32'h3FFF3FFF
`define SDVT_MSK_LO13 32'h00001FFF
`define SDVT_MSK_SLAVE 32'h0000003F
`define SDVT_MSK_POL 32'h0000010F
`define SDVT_MSK_MODE 32'h0000003D
`define SDVT_MSK_CTL 32'h00000F01
`define SDVT_MSK_CC 32'h0000FFFF
// ==================================================
// field positions
`define SDVT_LO 12:0
`define SDVT_HI 28:16
`define SDVT_B_RUN 0
`define SDVT_B_SLV 0
`define SDVT_B_HIP 1
`define SDVT_B_VIP 2
`define SDVT_B_FIP 3
`define SDVT_F_FMD 5:4
`define SDVT_B_HSP 0
`define SDVT_B_VSP 1
`define SDVT_B_FDP 2
`define SDVT_B_AVP 3
`define SDVT_B_DTP 8
`define SDVT_B_F0 13
`define SDVT_B_F1 29
`define SDVT_B_UEL 3
`define SDVT_B_INTERLACE_SEL 2
`define SDVT_F_FMT 11:8
`define SDVT_B_FMON 4
`define SDVT_B_CAE 1
`define SDVT_B_CAO 0
// ==================================================
// field detect modes and scan formats
`define SDVT_FMD_LATCH 2'h0
`define SDVT_FMD_RAW 2'h1
`define SDVT_FMD_VS 2'h2
`define SDVT_FMD_PHASE 2'h3
`define SDVT_FMT_525 4'h0
`define SDVT_FMT_625 4'h1
// caption lines, counted from 1 in the frame
`define SDVT_CC_ODD_525 13'h0015
`define SDVT_CC_ODD_625 13'h0016
`define SDVT_CC_EVEN_525 13'h011C
`define SDVT_CC_EVEN_625 13'h014F
`endif

//--- rtl/sdvt_timing.v
// timing and sync generator of a standard-definition video encoder
// assumes an apb master on clock_i; sync pins are asynchronous
`include "sdvt_consts.vh"
module sdvt_timing #(
   parameter CW = 13
) (
   input wire clock_i,
   input wire rst_n_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   input wire ext_hsync_i,
   input wire ext_vsync_i,
   input wire ext_field_i,
   output reg hsync_o,
   output reg vsync_o,
   output reg field_o,
   output reg active_video_o,
   output reg detect_pulse_o,
   output reg irq_pulse_o,
   output reg caption_even_send_o,
   output reg caption_odd_send_o
);
   // ==================================================
   // register bus
   reg [31:0] mode_reg, sync_slave_control, picture_size, output_polarity;
   reg [31:0] hsync_out_pixels, vsync_out_pixels, vsync_out_lines;
   reg [31:0] field_out_toggle_pixel, field_out_start;
   reg [31:0] active_video_out_pixels, active_video_out_lines_f0;
   reg [31:0] active_video_out_lines_f1, detect_pulse_pixels;
   reg [31:0] detect_pulse_lines, interrupt_position, encoder_control;
   reg [15:0] caption_even_data, caption_odd_data;
   reg caption_even_pending, caption_odd_pending, field_monitor;
   reg [31:0] rdata;
   reg hit;
   wire wr = psel_i & penable_i & pwrite_i;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit;
   assign prdata_o = (psel_i & penable_i & ~pwrite_i) ? rdata : 32'h0;

   always @* begin
      hit = 1'b1;
      case (paddr_i)
         `SDVT_OFS_MODE: rdata = mode_reg;
         `SDVT_OFS_SLAVE: rdata = sync_slave_control;
         `SDVT_OFS_SIZE: rdata = picture_size;
         `SDVT_OFS_POL: rdata = output_polarity;
         `SDVT_OFS_HS: rdata = hsync_out_pixels;
         `SDVT_OFS_VSP: rdata = vsync_out_pixels;
         `SDVT_OFS_VSL: rdata = vsync_out_lines;
         `SDVT_OFS_FTP: rdata = field_out_toggle_pixel;
         `SDVT_OFS_FST: rdata = field_out_start;
         `SDVT_OFS_AVP: rdata = active_video_out_pixels;
         `SDVT_OFS_AVL0: rdata = active_video_out_lines_f0;
         `SDVT_OFS_AVL1: rdata = active_video_out_lines_f1;
         `SDVT_OFS_DTP: rdata = detect_pulse_pixels;
         `SDVT_OFS_DTL: rdata = detect_pulse_lines;
         `SDVT_OFS_IRQ: rdata = interrupt_position;
         `SDVT_OFS_STAT: begin
            rdata = 32'h0;
            rdata[`SDVT_B_FMON] = field_monitor;
            rdata[`SDVT_B_CAE] = caption_even_pending;
            rdata[`SDVT_B_CAO] = caption_odd_pending;
         end
         `SDVT_OFS_CTL: rdata = encoder_control;
         `SDVT_OFS_CCE: rdata = {16'h0, caption_even_data};
         `SDVT_OFS_CCO: rdata = {16'h0, caption_odd_data};
         default: begin
            rdata = 32'h0;
            hit = 1'b0;
         end
      endcase
   end

   wire wr_cce = wr & (paddr_i == `SDVT_OFS_CCE);
   wire wr_cco = wr & (paddr_i == `SDVT_OFS_CCO);

   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         mode_reg <= `SDVT_RST_MODE;
         sync_slave_control <= 32'h0;
         picture_size <= `SDVT_RST_SIZE; // [R6] [R7]
         output_polarity <= 32'h0;
         hsync_out_pixels <= 32'h0;
         vsync_out_pixels <= 32'h0;
         vsync_out_lines <= 32'h0;
         field_out_toggle_pixel <= 32'h0;
         field_out_start <= `SDVT_RST_FST; // [R12]
         active_video_out_pixels <= 32'h0;
         active_video_out_lines_f0 <= 32'h0;
         active_video_out_lines_f1 <= 32'h0;
         detect_pulse_pixels <= 32'h0;
         detect_pulse_lines <= 32'h0;
         interrupt_position <= 32'h0;
         encoder_control <= 32'h0;
         caption_even_data <= 16'h0;
         caption_odd_data <= 16'h0;
      end else if (wr) begin
         case (paddr_i)
            `SDVT_OFS_MODE: mode_reg <= pwdata_i & `SDVT_MSK_MODE;
            `SDVT_OFS_SLAVE:
               sync_slave_control <= pwdata_i & `SDVT_MSK_SLAVE;
            `SDVT_OFS_SIZE: picture_size <= pwdata_i & `SDVT_MSK_PAIR;
            `SDVT_OFS_POL: output_polarity <= pwdata_i & `SDVT_MSK_POL;
            `SDVT_OFS_HS: hsync_out_pixels <= pwdata_i & `SDVT_MSK_PAIR;
            `SDVT_OFS_VSP: vsync_out_pixels <= pwdata_i & `SDVT_MSK_PAIR;
            `SDVT_OFS_VSL: vsync_out_lines <= pwdata_i & `SDVT_MSK_PAIR;
            `SDVT_OFS_FTP:
               field_out_toggle_pixel <= pwdata_i & `SDVT_MSK_LO13;
            `SDVT_OFS_FST: field_out_start <= pwdata_i & `SDVT_MSK_FST;
            `SDVT_OFS_AVP:
               active_video_out_pixels <= pwdata_i & `SDVT_MSK_PAIR;
            `SDVT_OFS_AVL0:
               active_video_out_lines_f0 <= pwdata_i & `SDVT_MSK_PAIR;
            `SDVT_OFS_AVL1:
               active_video_out_lines_f1 <= pwdata_i & `SDVT_MSK_PAIR;
            `SDVT_OFS_DTP: detect_pulse_pixels <= pwdata_i & `SDVT_MSK_PAIR;
            `SDVT_OFS_DTL: detect_pulse_lines <= pwdata_i & `SDVT_MSK_PAIR;
            `SDVT_OFS_IRQ: interrupt_position <= pwdata_i & `SDVT_MSK_PAIR;
            `SDVT_OFS_CTL: encoder_control <= pwdata_i & `SDVT_MSK_CTL;
            `SDVT_OFS_CCE: caption_even_data <= pwdata_i[15:0];
            `SDVT_OFS_CCO: caption_odd_data <= pwdata_i[15:0];
            default: ;
         endcase
      end
   end

   // ==================================================
   // control decode
   wire encoder_run = mode_reg[`SDVT_B_RUN];
   wire run_rst = ~rst_n_i | ~encoder_run; // [R1]
   wire master_slave_sel = sync_slave_control[`SDVT_B_SLV];
   wire [1:0] field_detect_sel = sync_slave_control[`SDVT_F_FMD];
   wire [CW-1:0] lines_per_frame = picture_size[`SDVT_HI];
   wire [CW-1:0] clocks_per_line = picture_size[`SDVT_LO];
   wire interlace_sel = mode_reg[`SDVT_B_INTERLACE_SEL];
   wire unequal_field_lines = mode_reg[`SDVT_B_UEL];
   wire [3:0] scan_format = encoder_control[`SDVT_F_FMT]; // [R19]
   wire field0_start_field = field_out_start[`SDVT_B_F0];
   wire field1_start_field = field_out_start[`SDVT_B_F1];
   wire [CW-1:0] field_toggle_pixel = field_out_toggle_pixel[`SDVT_LO];

   // ==================================================
   // external sync inputs: two flops, then polarity
   reg [2:0] sync_m, sync_s, sync_d;
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         sync_m <= 3'h0;
         sync_s <= 3'h0;
         sync_d <= 3'h0;
      end else begin
         sync_m <= {ext_field_i, ext_vsync_i, ext_hsync_i};
         sync_s <= sync_m;
         sync_d <= sync_s;
      end
   end
   wire [2:0] pol_in = {sync_slave_control[`SDVT_B_FIP],
      sync_slave_control[`SDVT_B_VIP], sync_slave_control[`SDVT_B_HIP]};
   wire [2:0] ext_now = sync_s ^ pol_in; // [R4] [R5]
   wire [2:0] ext_old = sync_d ^ pol_in;
   wire hs_rise = ext_now[0] & ~ext_old[0];
   wire vs_rise = ext_now[1] & ~ext_old[1];

   // ==================================================
   // counters
   reg [CW-1:0] pix, line, field_len_cnt;
   reg ueq_phase;
   wire line_end = (pix == clocks_per_line - 1'b1);
   wire frame_end = (line == lines_per_frame - 1'b1);
   // field length from the frame count; only field_len_cnt and ueq_phase use it
   wire [CW-1:0] half_lo = (lines_per_frame - 1'b1) >> 1;
   wire [CW-1:0] half_hi = (lines_per_frame + 1'b1) >> 1;
   wire [CW-1:0] field_len = (interlace_sel & unequal_field_lines) ?
      (ueq_phase ? half_hi : half_lo) : (lines_per_frame >> 1); // [R20]

   always @(posedge clock_i) begin
      if (run_rst) begin // [R1]
         pix <= {CW{1'b0}};
         line <= {CW{1'b0}};
         field_len_cnt <= {CW{1'b0}};
         ueq_phase <= 1'b0;
      end else if (master_slave_sel & hs_rise) begin // [R2]
         pix <= {CW{1'b0}};
         line <= vs_rise ? {CW{1'b0}} : line + 1'b1;
      end else if (master_slave_sel & vs_rise) begin // [R2]
         line <= {CW{1'b0}};
         pix <= line_end ? {CW{1'b0}} : pix + 1'b1;
      end else if (line_end) begin // [R21]
         pix <= {CW{1'b0}};
         line <= frame_end ? {CW{1'b0}} : line + 1'b1;
         if (frame_end || field_len_cnt == field_len - 1'b1) begin
            field_len_cnt <= {CW{1'b0}};
            ueq_phase <= ~ueq_phase; // [R20]
         end else begin
            field_len_cnt <= field_len_cnt + 1'b1;
         end
      end else begin
         pix <= pix + 1'b1;
      end
   end

   // ==================================================
   // field id: internal toggling or slave detection
   reg fid, ext_fid_latched;
   wire fid_start0 = (line == field_out_start[`SDVT_LO]);
   wire fid_start1 = (line == field_out_start[`SDVT_HI]);
   wire at_fpix = (pix == field_toggle_pixel);
   always @(posedge clock_i) begin
      if (run_rst) begin
         fid <= 1'b0;
         ext_fid_latched <= 1'b0;
      end else if (master_slave_sel) begin
         if (vs_rise) ext_fid_latched <= ext_now[2];
         case (field_detect_sel) // [R3]
            `SDVT_FMD_LATCH: fid <= vs_rise ? ext_now[2] : ext_fid_latched;
            `SDVT_FMD_RAW: fid <= ext_now[2];
            `SDVT_FMD_VS: fid <= ext_now[1];
            // vsync leading mid-line marks the second field
            `SDVT_FMD_PHASE: if (vs_rise) fid <= ~hs_rise & ~line_end;
            default: fid <= fid;
         endcase
      end else if (at_fpix) begin
         if (~interlace_sel & field0_start_field) begin
            if (frame_end) fid <= ~fid; // [R13]
         end else if (fid_start1) begin
            fid <= field1_start_field; // [R11] [R12]
         end else if (fid_start0) begin
            fid <= field0_start_field; // [R11] [R12]
         end
      end
   end

   // ==================================================
   // windows and outputs
   function in_win;
      input [CW-1:0] v, sta, stp;
      begin
         in_win = (v >= sta) && (v < stp);
      end
   endfunction

   // vsync goes on at start pixel of start line, off at stop of stop line
   wire vs_on = (line > vsync_out_lines[`SDVT_LO] ||
      (line == vsync_out_lines[`SDVT_LO] &&
      pix >= vsync_out_pixels[`SDVT_LO])) &&
      (line < vsync_out_lines[`SDVT_HI] ||
      (line == vsync_out_lines[`SDVT_HI] &&
      pix < vsync_out_pixels[`SDVT_HI]));
   wire [31:0] av_lines = fid ? active_video_out_lines_f1 :
      active_video_out_lines_f0;
   wire active_video_flag =
      in_win(pix, active_video_out_pixels[`SDVT_LO],
      active_video_out_pixels[`SDVT_HI]) &&
      in_win(line, av_lines[`SDVT_LO], av_lines[`SDVT_HI]); // [R14]
   wire det_on = in_win(pix, detect_pulse_pixels[`SDVT_LO],
      detect_pulse_pixels[`SDVT_HI]) &&
      in_win(line, detect_pulse_lines[`SDVT_LO],
      detect_pulse_lines[`SDVT_HI]); // [R15]
   wire hs_on = in_win(pix, hsync_out_pixels[`SDVT_LO],
      hsync_out_pixels[`SDVT_HI]); // [R9]
   wire irq_hit = (line == interrupt_position[`SDVT_HI]) &&
      (pix == interrupt_position[`SDVT_LO]); // [R16]

   // caption lines are 1-based; the line counter is 0-based
   wire is625 = (scan_format == `SDVT_FMT_625);
   wire [CW-1:0] cc_odd_line = is625 ? `SDVT_CC_ODD_625 : `SDVT_CC_ODD_525;
   wire [CW-1:0] cc_even_line = is625 ? `SDVT_CC_EVEN_625 :
      `SDVT_CC_EVEN_525;
   wire cc_odd_done = line_end && (line + 1'b1 == cc_odd_line);
   wire cc_even_done = line_end && (line + 1'b1 == cc_even_line);

   always @(posedge clock_i) begin
      if (run_rst) begin
         hsync_o <= output_polarity[`SDVT_B_HSP];
         vsync_o <= output_polarity[`SDVT_B_VSP];
         field_o <= output_polarity[`SDVT_B_FDP];
         active_video_o <= output_polarity[`SDVT_B_AVP];
         detect_pulse_o <= output_polarity[`SDVT_B_DTP];
         irq_pulse_o <= 1'b0;
         caption_even_send_o <= 1'b0;
         caption_odd_send_o <= 1'b0;
         field_monitor <= 1'b0;
      end else begin
         hsync_o <= hs_on ^ output_polarity[`SDVT_B_HSP]; // [R8]
         vsync_o <= vs_on ^ output_polarity[`SDVT_B_VSP]; // [R10] [R8]
         field_o <= fid ^ output_polarity[`SDVT_B_FDP]; // [R8]
         active_video_o <= active_video_flag ^
            output_polarity[`SDVT_B_AVP]; // [R8]
         detect_pulse_o <= det_on ^ output_polarity[`SDVT_B_DTP]; // [R8]
         irq_pulse_o <= irq_hit;
         caption_even_send_o <= cc_even_done & caption_even_pending;
         caption_odd_send_o <= cc_odd_done & caption_odd_pending;
         field_monitor <= fid;
      end
   end

   // ==================================================
   // caption pending flags; a write in the clearing cycle keeps it set
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         caption_even_pending <= 1'b0;
         caption_odd_pending <= 1'b0;
      end else begin
         if (wr_cce)
            caption_even_pending <= 1'b1; // [R17]
         else if (encoder_run & cc_even_done)
            caption_even_pending <= 1'b0; // [R17]
         if (wr_cco)
            caption_odd_pending <= 1'b1; // [R18]
         else if (encoder_run & cc_odd_done)
            caption_odd_pending <= 1'b0; // [R18]
      end
   end
endmodule // sdvt_timing

//--- tb/sdvt_sync_src.sv
// external sync source that feeds the slave-mode sync pins
// assumes the bench clock; syncs sit at their inactive level when idle
module sdvt_sync_src #(
   parameter LINE = 20,
   parameter FRAME = 6
) (
   input wire logic clock_i,
   input wire logic en_i,
   input wire logic low_i,
   input wire logic fld_i,
   output logic hs_o,
   output logic vs_o,
   output logic fld_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int pix = 0;
   int line = 0;
   always @(posedge clock_i) begin
      if (!en_i) begin
         pix <= 0;
         line <= 0;
      end else begin
         pix <= (pix == LINE - 1) ? 0 : pix + 1;
         if (pix == LINE - 1) line <= (line == FRAME - 1) ? 0 : line + 1;
      end
   end
   // low_i flips the sense so the input polarity bits get exercised
   assign hs_o = (en_i && pix < 2) ^ low_i;
   assign vs_o = (en_i && line == 0) ^ low_i;
   assign fld_o = fld_i;
endmodule // sdvt_sync_src

//--- tb/sdvt_timing_assertions.sv
// checker of the sd video timing generator, bound to its top ports
// assumes one clock, synchronous active-low reset, zero-wait apb
module sdvt_timing_assertions #(
   parameter CW = 13
) (
   input wire clock_i,
   input wire rst_n_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o,
   input wire hsync_o,
   input wire vsync_o,
   input wire active_video_o,
   input wire detect_pulse_o,
   input wire irq_pulse_o,
   input wire caption_even_send_o,
   input wire caption_odd_send_o
);
   // =========================================
   // shadow of the settings the properties need
   reg run_q;
   reg slv_q;
   reg pend_e;
   reg pend_o;
   reg [8:0] pol_q;
   reg [31:0] hs_q;
   reg [12:0] hs_cnt;
   wire wr = psel_i && penable_i && pwrite_i && pready_o;
   wire rd_stat = psel_i && penable_i && !pwrite_i && paddr_i == 12'h080;
   wire hs_act = hsync_o ^ pol_q[0];
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         run_q <= 1'b0;
         slv_q <= 1'b0;
         pend_e <= 1'b0;
         pend_o <= 1'b0;
         pol_q <= 9'h000;
         hs_q <= 32'h00000000;
         hs_cnt <= 13'h0000;
      end else begin
         if (wr && paddr_i == 12'h004) run_q <= pwdata_i[0];
         if (wr && paddr_i == 12'h008) slv_q <= pwdata_i[0];
         if (wr && paddr_i == 12'h010) pol_q <= pwdata_i[8:0];
         if (wr && paddr_i == 12'h014) hs_q <= pwdata_i;
         if (caption_even_send_o) pend_e <= 1'b0;
         if (wr && paddr_i == 12'h128) pend_e <= 1'b1;
         if (caption_odd_send_o) pend_o <= 1'b0;
         if (wr && paddr_i == 12'h12C) pend_o <= 1'b1;
         hs_cnt <= hs_act ? hs_cnt + 13'h0001 : 13'h0000;
      end
   end
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   // =========================================
   // properties
   apb_ready_a: assert property (psel_i && penable_i |-> pready_o)
      else $error("apb access not answered at once");
   unmapped_err_a: assert property (psel_i && penable_i && paddr_i == 12'h000
      |-> pslverr_o && prdata_o == 32'h00000000)
      else $error("unmapped access not refused");
   run_off_quiet_a: assert property (
      !run_q && !$past(run_q) && $stable(pol_q) |-> hsync_o == pol_q[0]
      && vsync_o == pol_q[1] && active_video_o == pol_q[3]
      && detect_pulse_o == pol_q[8] && !irq_pulse_o)
      else $error("outputs active while encoder stopped");
   hs_width_a: assert property (
      $fell(hs_act) && run_q && !slv_q && hs_q[28:16] > hs_q[12:0]
      |-> hs_cnt == hs_q[28:16] - hs_q[12:0])
      else $error("hsync width differs from stop minus start");
   irq_one_cycle_a: assert property (irq_pulse_o |=> !irq_pulse_o)
      else $error("irq pulse longer than one cycle");
   cap_even_a: assert property (caption_even_send_o |-> pend_e)
      else $error("even caption sent while not pending");
   cap_odd_a: assert property (caption_odd_send_o |-> pend_o)
      else $error("odd caption sent while not pending");
   status_bits_a: assert property (
      rd_stat |-> prdata_o[1] == (pend_e && !caption_even_send_o)
      && prdata_o[0] == (pend_o && !caption_odd_send_o)
      && prdata_o[31:5] == 27'h0 && prdata_o[3:2] == 2'h0)
      else $error("status read disagrees with caption state");
   irq_seen_c: cover property (irq_pulse_o);
   cap_seen_c: cover property (caption_even_send_o);
   hs_seen_c: cover property ($fell(hs_act) && run_q);
endmodule // sdvt_timing_assertions

bind sdvt_timing sdvt_timing_assertions #(.CW(CW)) chk (
   .clock_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
   .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .hsync_o, .vsync_o,
   .active_video_o, .detect_pulse_o, .irq_pulse_o,
   .caption_even_send_o, .caption_odd_send_o);

//--- tb/sdvt_timing_bench.sv
// self-checking bench of the sd video timing generator
// assumes the sync source model and the bound checker
module sdvt_timing_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h00000000;
   logic src_en = 1'b0;
   logic src_low = 1'b0;
   logic src_fld = 1'b0;
   wire [31:0] prdata_o;
   wire pready_o, pslverr_o, ext_hsync_i, ext_vsync_i, ext_field_i;
   wire hsync_o, vsync_o, field_o, active_video_o, detect_pulse_o;
   wire irq_pulse_o, caption_even_send_o, caption_odd_send_o;
   int err_total = 0;
   int checks = 0;
   logic [31:0] rd;
   logic er;
   always #12.5 clock_i = ~clock_i;
   sdvt_timing #(.CW(13)) DUT (.clock_i, .rst_n_i, .psel_i, .penable_i,
      .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
      .ext_hsync_i, .ext_vsync_i, .ext_field_i, .hsync_o, .vsync_o,
      .field_o, .active_video_o, .detect_pulse_o, .irq_pulse_o,
      .caption_even_send_o, .caption_odd_send_o);
   sdvt_sync_src #(.LINE(20), .FRAME(6)) SRC (.clock_i, .en_i(src_en),
      .low_i(src_low), .fld_i(src_fld), .hs_o(ext_hsync_i),
      .vs_o(ext_vsync_i), .fld_o(ext_field_i));
   // =========================================
   // shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one idle edge closes every transfer so psel never changes twice
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clock_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      check(rd, exp);
   endtask
   task automatic run(input logic on);
      wr(12'h004, {31'h00000002, on});
   endtask
   task automatic wait_hs(input logic lvl, output int c);
      c = 0;
      do begin
         @(posedge clock_i);
         c++;
      end while (hsync_o !== lvl && c < 100);
   endtask
   // =========================================
   // scenarios
   task automatic t_regs;
      rdc(12'h00C, 32'h020D06B4);
      rdc(12'h024, 32'h20000000);
      rdc(12'h008, 32'h00000000);
      rdc(12'h084, 32'h00000000);
      rdc(12'h004, 32'h00000004);
      apb(1'b0, 12'h000, 32'h00000000);
      check(rd, 32'h00000000);
      check({31'h0, er}, 32'h00000001);
      wr(12'h00C, 32'hFFFFFFFF);
      rdc(12'h00C, 32'h1FFF1FFF);
      wr(12'h080, 32'hFFFFFFFF);
      rdc(12'h080, 32'h00000000);
   endtask
   task automatic t_hsync;
      int c, k;
      wr(12'h00C, 32'h00040010);
      wr(12'h014, 32'h00050002);
      wr(12'h05C, 32'h00020003);
      for (int p = 0; p < 2; p++) begin
         run(1'b0);
         wr(12'h010, p);
         run(1'b1);
         wait_hs(p == 0, k);
         wait_hs(p != 0, c);
         check(c, 3);
         wait_hs(p == 0, k);
         check(c + k, 16);
      end
      k = 0;
      while (irq_pulse_o !== 1'b1 && k < 100) begin
         @(posedge clock_i);
         k++;
      end
      c = 0;
      do begin
         @(posedge clock_i);
         c++;
      end while (irq_pulse_o !== 1'b1 && c < 100);
      check(c, 64);
   endtask
   task automatic t_runoff;
      int c;
      run(1'b0);
      wr(12'h010, 32'h00000000);
      c = 0;
      repeat (80) begin
         @(posedge clock_i);
         if (hsync_o !== 1'b0 || irq_pulse_o !== 1'b0) c++;
      end
      check(c, 0);
   endtask
   task automatic t_windows;
      int v = 0, a = 0, d = 0;
      wr(12'h018, 32'h00080004);
      wr(12'h01C, 32'h00020001);
      wr(12'h028, 32'h000A0003);
      wr(12'h030, 32'h00030001);
      wr(12'h054, 32'h00060005);
      wr(12'h058, 32'h00040000);
      run(1'b1);
      repeat (64) @(posedge clock_i);
      repeat (64) begin
         @(posedge clock_i);
         v += vsync_o;
         a += active_video_o;
         d += detect_pulse_o;
      end
      check(v, 20);
      check(a, 14);
      check(d, 4);
   endtask
   task automatic t_caption;
      int n;
      logic [3:0] fmt [4] = '{4'h0, 4'h1, 4'h0, 4'h1};
      int ln [4] = '{20, 21, 283, 334};
      wr(12'h00C, 32'h01540010);
      for (int i = 0; i < 4; i++) begin
         run(1'b0);
         wr(12'h084, {20'h0, fmt[i], 8'h00});
         wr(i < 2 ? 12'h12C : 12'h128, 32'h00001234);
         apb(1'b0, 12'h080, 32'h00000000);
         check(rd[i / 2], 1'b1);
         run(1'b1);
         n = 1;
         do begin
            @(posedge clock_i);
            n++;
         end while ((i < 2 ? caption_odd_send_o : caption_even_send_o)
            !== 1'b1 && n < 6000);
         check((n - 3) / 16, ln[i]);
         apb(1'b0, 12'h080, 32'h00000000);
         check(rd[i / 2], 1'b0);
      end
   endtask
   task automatic t_slave;
      int c, k;
      run(1'b0);
      wr(12'h00C, 32'h00040020);
      wr(12'h008, 32'h00000017);
      src_low <= 1'b1;
      src_fld <= 1'b1;
      src_en <= 1'b1;
      run(1'b1);
      repeat (3) begin
         wait_hs(1'b1, k);
         wait_hs(1'b0, c);
      end
      wait_hs(1'b1, k);
      check(c + k, 20);
      apb(1'b0, 12'h080, 32'h00000000);
      check(rd[4], 1'b1);
      check(field_o, 1'b1);
      wr(12'h008, 32'h0000001F);
      repeat (8) @(posedge clock_i);
      apb(1'b0, 12'h080, 32'h00000000);
      check(rd[4], 1'b0);
      check(field_o, 1'b0);
      run(1'b0);
      src_en <= 1'b0;
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #1ms;
      err_total++;
      end_of_test;
   end
   initial begin
      repeat (3) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      t_regs;
      t_hsync;
      t_runoff;
      t_windows;
      t_caption;
      t_slave;
      end_of_test;
   end
endmodule // sdvt_timing_bench
